//--- hdl/nvmlk_cfg.svh
/*
  Constants of the non-volatile lock, configuration and layout block.
  Assumes inclusion by bare name from the block's module, its assertions and its bench.
*/
// Behaviour
// R1: Two lock bits at positions 0 and 1; all lock byte bits reset to one.
// R2: Lock bit reads one unprogrammed, zero programmed; zero adds protection.
// R3: Only whole-chip erase returns lock bits to one.
// R4: Both lock bits one: level 1, no protection.
// R5: Level 2 blocks flash programming and locks configuration in programming mode.
// R6: Level 3 also blocks flash readback, in programming mode.
// R7: Programmer should program configuration bits before lock bits.
// R8: Four sections, 8-word pages; address bits [3:1] pick the word.
// R9: Code 1024 bytes/64 pages or 512/32; bits [9:4] pick the page.
// R10: Signature and calibration sections are read-only; writes and erases refused.
// R11: Configuration byte is low byte of word 0x00; the rest reserved.
// R12: Bit 2 clock out, bit 1 watchdog on, bit 0 reset disable; default ones.
// R13: Chip erase keeps configuration; only configuration section erase restores it.
// R14: Configuration changes refused while lock bit one is programmed.
// R15: Configuration latched at every reset and on leaving programming mode.
// R16: New configuration takes no effect until programming mode exits.
// R17: Three identification bytes in signature words 0x00 and 0x01.
// R18: Oscillator trim copied from calibration word 0x00 during reset.
// R19: Application writes and erases to non-volatile memory always fail.
// R20: Lock combination bit two programmed, bit one not, treated as level 3.
`ifndef NVMLK_CFG_SVH
`define NVMLK_CFG_SVH
`define NVMLK_LOCK_RESET    8'hFF
`define NVMLK_CFG_RESET     8'hFF
`define NVMLK_LOCK_ONE_BIT  0
`define NVMLK_LOCK_TWO_BIT  1
`define NVMLK_RSTDIS_BIT    0
`define NVMLK_WDT_BIT       1
`define NVMLK_SYSCLK_OUTPUT_FUSE_BIT     2
`define NVMLK_PAGE_WORDS    8
`define NVMLK_WORD_MSB      3
`define NVMLK_WORD_LSB      1
`define NVMLK_PAGE_MSB      9
`define NVMLK_PAGE_LSB      4
`define NVMLK_CODE_WORDS    512
`define NVMLK_CODE_BYTES_L  11'h0400
`define NVMLK_CODE_BYTES_S  11'h0200
`define NVMLK_SECT_WORDS    8
`define NVMLK_SIG_WORDS     16
`define NVMLK_CFG_WORD      4'h0
`define NVMLK_CAL_WORD      4'h0
`define NVMLK_SIG_WORD0     4'h0
`define NVMLK_SIG_WORD1     4'h1
`define NVMLK_MAKER_ID      8'h5A
`define NVMLK_PART_ID1      8'h3C
`define NVMLK_PART_ID2      8'h71
`define NVMLK_TRIM_DEFAULT  8'h80
`endif

//--- hdl/nvmlk_pkg.sv
/*
  Types of the non-volatile lock, configuration and layout block.
  Assumes the constants header sits beside it.
*/
package nvmlk_pkg;
  typedef enum logic [1:0] {
    NVMLK_SEC_CODE,
    NVMLK_SEC_CFG,
    NVMLK_SEC_SIG,
    NVMLK_SEC_CAL
  } nvmlk_section_t;

  typedef enum logic [1:0] {
    NVMLK_OP_WRITE,
    NVMLK_OP_SECTION_ERASE,
    NVMLK_OP_CHIP_ERASE,
    NVMLK_OP_LOCK_WRITE
  } nvmlk_op_t;

  typedef enum logic [1:0] {
    NVMLK_LEVEL_1,
    NVMLK_LEVEL_2,
    NVMLK_LEVEL_3
  } nvmlk_level_t;

  typedef struct packed {
    logic           valid;
    logic           from_app;
    nvmlk_op_t      op;
    nvmlk_section_t section;
    logic [9:0]     addr;
    logic [15:0]    data;
  } nvmlk_req_t;

  typedef struct packed {
    logic sysclk_output_fuse;
    logic watchdog_forced_on;
    logic ext_reset_disable;
  } nvmlk_fuses_t;
endpackage : nvmlk_pkg

//--- hdl/nvmlk_core.sv
/*
  Lock bits, configuration, signature and calibration storage with the
  flash code array and its protection checks.
  Assumes a single 100 MHz clock, synchronous active-high reset, and a
  requester that presents one operation per cycle on the request struct.
*/
`timescale 1ns/1ns
`include "nvmlk_cfg.svh"
module nvmlk_core
  import nvmlk_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         prog_mode,
  input  wire nvmlk_req_t   req,
  input  wire logic         rd_en,
  input  wire nvmlk_section_t rd_section,
  input  wire logic [9:0]   rd_addr,
  output logic [7:0]        rd_data,
  output logic              rd_refused,
  output logic              req_refused,
  output logic              req_done,
  output logic [7:0]        protection_byte,
  output nvmlk_level_t      lock_level,
  output nvmlk_fuses_t      fuses,
  output logic [7:0]        osc_trim_register
);
  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [15:0] code_mem [`NVMLK_CODE_WORDS];
  // Lock and configuration bytes start erased and are never touched by reset.
  logic [7:0]  config_fuse_byte = `NVMLK_CFG_RESET; // R12
  logic [7:0]  lock_store       = `NVMLK_LOCK_RESET; // R1
  logic [7:0]  osc_trim_store;
  logic        prog_mode_q;
  logic        write_ok;
  logic        leaving_prog;
  logic [8:0]  code_span_words;

  // The factory trim value is fixed; the bench cannot program it.
  assign osc_trim_store = `NVMLK_TRIM_DEFAULT; // R10

  // ----------------------------------------------------------------------
  // Address helpers
  // ----------------------------------------------------------------------
  function automatic logic [2:0] word_in_page_index(input logic [9:0] a);
    return a[`NVMLK_WORD_MSB:`NVMLK_WORD_LSB]; // R8
  endfunction : word_in_page_index

  function automatic logic [5:0] page_index(input logic [9:0] a);
    return a[`NVMLK_PAGE_MSB:`NVMLK_PAGE_LSB]; // R9
  endfunction : page_index

  function automatic logic [8:0] code_word(input logic [9:0] a);
    return {page_index(a), word_in_page_index(a)};
  endfunction : code_word

  // Smaller variant covers only half the code array.
  assign code_span_words = LARGE_VARIANT ? 9'h1FF : 9'h0FF; // R9

  // ----------------------------------------------------------------------
  // Protection level
  // ----------------------------------------------------------------------
  always_comb begin
    unique case ({protection_byte[`NVMLK_LOCK_TWO_BIT], protection_byte[`NVMLK_LOCK_ONE_BIT]})
      2'b11:   lock_level = NVMLK_LEVEL_1; // R4
      2'b10:   lock_level = NVMLK_LEVEL_2; // R5
      default: lock_level = NVMLK_LEVEL_3; // R6 R20
    endcase
  end

  // Writes are refused for application code, read-only sections and locked areas.
  always_comb begin
    write_ok = req.valid && !req.from_app && prog_mode; // R19
    unique case (req.op)
      NVMLK_OP_CHIP_ERASE: ;
      NVMLK_OP_LOCK_WRITE: ;
      default: begin
        if (req.section == NVMLK_SEC_SIG || req.section == NVMLK_SEC_CAL)
          write_ok = 1'b0; // R10
        if (req.section == NVMLK_SEC_CODE && lock_level != NVMLK_LEVEL_1)
          write_ok = 1'b0; // R5 R6
        if (req.section == NVMLK_SEC_CFG && !protection_byte[`NVMLK_LOCK_ONE_BIT])
          write_ok = 1'b0; // R14
        if (req.section == NVMLK_SEC_CODE && code_word(req.addr) > code_span_words)
          write_ok = 1'b0;
      end
    endcase
  end

  assign req_refused = req.valid && !write_ok;

  always_ff @(posedge clk) begin
    if (reset)
      req_done <= 1'b0;
    else
      req_done <= write_ok;
  end

  // ----------------------------------------------------------------------
  // Lock byte
  // ----------------------------------------------------------------------
  // The lock bits survive reset; only chip erase sets them back to ones.
  always_ff @(posedge clk) begin
    if (write_ok && req.op == NVMLK_OP_CHIP_ERASE)
      lock_store <= `NVMLK_LOCK_RESET; // R3
    else if (write_ok && req.op == NVMLK_OP_LOCK_WRITE)
      lock_store <= lock_store & req.data[7:0]; // R2
  end

  assign protection_byte = lock_store;

  // ----------------------------------------------------------------------
  // Code section
  // ----------------------------------------------------------------------
  // Chip and section erase of code loop over every word and rewrite it to ones:
  // tracking erased words by a per-word valid flag would cost more area than the array rewrite.
  always_ff @(posedge clk) begin
    if (write_ok && (req.op == NVMLK_OP_CHIP_ERASE ||
        (req.section == NVMLK_SEC_CODE && req.op == NVMLK_OP_SECTION_ERASE))) begin
      for (int i = 0; i < `NVMLK_CODE_WORDS; i++)
        code_mem[i] <= 16'hFFFF;
    end else if (write_ok && req.op == NVMLK_OP_WRITE && req.section == NVMLK_SEC_CODE) begin
      code_mem[code_word(req.addr)] <= code_mem[code_word(req.addr)] & req.data;
    end
  end

  // ----------------------------------------------------------------------
  // Configuration section
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (write_ok && req.section == NVMLK_SEC_CFG && req.op == NVMLK_OP_SECTION_ERASE)
      config_fuse_byte <= `NVMLK_CFG_RESET; // R13
    else if (write_ok && req.section == NVMLK_SEC_CFG && req.op == NVMLK_OP_WRITE &&
             word_in_page_index(req.addr) == 3'(`NVMLK_CFG_WORD))
      config_fuse_byte <= config_fuse_byte & req.data[7:0]; // R11
  end

  // ----------------------------------------------------------------------
  // Working latches
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset)
      prog_mode_q <= 1'b0;
    else
      prog_mode_q <= prog_mode;
  end

  assign leaving_prog = prog_mode_q && !prog_mode;

  always_ff @(posedge clk) begin
    if (reset || leaving_prog) begin // R15 R16
      fuses.sysclk_output_fuse <= config_fuse_byte[`NVMLK_SYSCLK_OUTPUT_FUSE_BIT]; // R12
      fuses.watchdog_forced_on <= config_fuse_byte[`NVMLK_WDT_BIT];
      fuses.ext_reset_disable  <= config_fuse_byte[`NVMLK_RSTDIS_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (reset)
      osc_trim_register <= osc_trim_store; // R18
  end

  // ----------------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------------
  // Readback of code is blocked at level 3 only toward the programmer.
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data    <= 8'h00;
      rd_refused <= 1'b0;
    end else if (rd_en) begin
      rd_refused <= 1'b0;
      rd_data    <= 8'hFF;
      unique case (rd_section)
        NVMLK_SEC_CODE: begin
          if (prog_mode && lock_level == NVMLK_LEVEL_3)
            rd_refused <= 1'b1; // R6
          else if (code_word(rd_addr) <= code_span_words)
            rd_data <= rd_addr[0] ? code_mem[code_word(rd_addr)][15:8]
                                  : code_mem[code_word(rd_addr)][7:0];
        end
        NVMLK_SEC_CFG: begin
          if (word_in_page_index(rd_addr) == 3'(`NVMLK_CFG_WORD) && !rd_addr[0])
            rd_data <= config_fuse_byte; // R11
        end
        NVMLK_SEC_SIG: begin
          if (rd_addr[4:1] == `NVMLK_SIG_WORD0)
            rd_data <= rd_addr[0] ? `NVMLK_PART_ID1 : `NVMLK_MAKER_ID; // R17
          else if (rd_addr[4:1] == `NVMLK_SIG_WORD1 && !rd_addr[0])
            rd_data <= `NVMLK_PART_ID2;
        end
        NVMLK_SEC_CAL: begin
          if (word_in_page_index(rd_addr) == 3'(`NVMLK_CAL_WORD) && !rd_addr[0])
            rd_data <= osc_trim_store;
        end
      endcase
    end
  end
endmodule : nvmlk_core

//--- testbench/nvmlk_core_sva.sv
/* Assertions for the lock, configuration and layout block.
   Assumes a bind to nvmlk_core with one clock and synchronous reset. */
`timescale 1ns/1ns
`include "nvmlk_cfg.svh"
module nvmlk_core_sva
  import nvmlk_pkg::*;
#(parameter bit LARGE_VARIANT = 1'b1) (
  input wire logic           clk,
  input wire logic           reset,
  input wire logic           prog_mode,
  input wire nvmlk_req_t     req,
  input wire logic           rd_en,
  input wire nvmlk_section_t rd_section,
  input wire logic [7:0]     rd_data,
  input wire logic           rd_refused,
  input wire logic           req_refused,
  input wire logic [7:0]     protection_byte,
  input wire nvmlk_level_t   lock_level,
  input wire nvmlk_fuses_t   fuses,
  input wire logic [7:0]     osc_trim_register
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // -------------------------------------------------------------------
  // Checks
  // -------------------------------------------------------------------
  a_level_map: assert property (lock_level == (protection_byte[1:0] == 2'b11 ? NVMLK_LEVEL_1
    : protection_byte[1:0] == 2'b10 ? NVMLK_LEVEL_2 : NVMLK_LEVEL_3)) else $error("bad level");
  a_app_refused: assert property (req.valid && req.from_app |-> req_refused)
    else $error("app access taken");
  a_ro_refused: assert property (req.valid && req.section inside {NVMLK_SEC_SIG, NVMLK_SEC_CAL}
    && req.op inside {NVMLK_OP_WRITE, NVMLK_OP_SECTION_ERASE} |-> req_refused)
    else $error("read-only section changed");
  a_cfg_locked: assert property (req.valid && req.section == NVMLK_SEC_CFG
    && req.op inside {NVMLK_OP_WRITE, NVMLK_OP_SECTION_ERASE} && !protection_byte[0]
    |-> req_refused)
    else $error("locked config changed");
  a_code_locked: assert property (req.valid && req.section == NVMLK_SEC_CODE
    && req.op == NVMLK_OP_WRITE && lock_level != NVMLK_LEVEL_1 |-> req_refused)
    else $error("locked code written");
  a_lock_erase: assert property (|(protection_byte & ~$past(protection_byte)) |->
    $past(req.valid && req.op == NVMLK_OP_CHIP_ERASE && !req_refused)) else $error("lock undone");
  a_fuse_hold: assert property (prog_mode && $past(prog_mode) && !$past(reset) |->
    $stable(fuses)) else $error("fuses moved");
  a_trim_load: assert property ($past(reset) |-> osc_trim_register == `NVMLK_TRIM_DEFAULT)
    else $error("trim not loaded");
  a_read_block: assert property (rd_en && prog_mode && rd_section == NVMLK_SEC_CODE
    && lock_level == NVMLK_LEVEL_3 |=> rd_refused && rd_data == 8'hFF) else $error("read leak");
  c_level3: cover property (lock_level == NVMLK_LEVEL_3);
  c_taken: cover property (req.valid && !req_refused);
  c_refused: cover property (req.valid && req_refused);
endmodule : nvmlk_core_sva

bind nvmlk_core nvmlk_core_sva #(.LARGE_VARIANT(LARGE_VARIANT)) u_sva (.clk, .reset, .prog_mode,
  .req, .rd_en, .rd_section, .rd_data, .rd_refused, .req_refused, .protection_byte, .lock_level,
  .fuses, .osc_trim_register);

//--- testbench/nvmlk_prog_model.sv
/* Programmer-side model that turns bench commands into requests.
   Assumes one command per cycle from the bench. */
`timescale 1ns/1ns
module nvmlk_prog_model
  import nvmlk_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire nvmlk_req_t cmd,
  output nvmlk_req_t      req
);
  // Idle fields are inverted so a stale request can never pass for a live one.
  always_ff @(posedge clk) begin
    req <= (reset || !cmd.valid) ? nvmlk_req_t'({1'b0, ~cmd[30:0]}) : cmd;
  end
endmodule : nvmlk_prog_model

//--- testbench/test_nvmlk_core.sv
/* Bench for nvmlk_core: programmer and application requests with readback.
   Assumes the package, the constants header and the model are compiled first. */
`timescale 1ns/1ns
`include "nvmlk_cfg.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin fails++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module test_nvmlk_core
  import nvmlk_pkg::*;
;
  logic           clk = 1'b0, reset = 1'b1, prog_mode = 1'b0, rd_en = 1'b0;
  logic [9:0]     rd_addr = 10'h000;
  nvmlk_section_t rd_section = NVMLK_SEC_CODE;
  nvmlk_req_t     cmd = '0, req;
  logic [7:0]     rd_data, protection_byte, osc_trim_register;
  logic           rd_refused, req_refused, req_done;
  nvmlk_level_t   lock_level;
  nvmlk_fuses_t   fuses;
  int             fails = 0, checked = 0;
  always #5 clk = ~clk;
  nvmlk_prog_model PM (.clk, .reset, .cmd, .req);
  nvmlk_core #(.LARGE_VARIANT(1'b1)) DUT (.clk, .reset, .prog_mode, .req, .rd_en, .rd_section,
    .rd_addr, .rd_data, .rd_refused, .req_refused, .req_done, .protection_byte, .lock_level,
    .fuses, .osc_trim_register);
  // -------------------------------------------------------------------
  // Access tasks
  // -------------------------------------------------------------------
  task automatic op(input logic p, input nvmlk_op_t o, input nvmlk_section_t s,
                    input logic [9:0] a, input logic [15:0] d, input logic x);
    @(posedge clk) cmd <= '{1'b1, p, o, s, a, d};
    @(posedge clk) cmd.valid <= 1'b0;
    #1 `CHK(req_refused, x)
    @(posedge clk) #1 `CHK(req_done, !x)
  endtask : op
  task automatic rd(input nvmlk_section_t s, input logic [9:0] a, input logic [7:0] e,
                    input logic r);
    @(posedge clk) begin
      rd_en <= 1'b1;
      rd_section <= s;
      rd_addr <= a;
    end
    @(posedge clk) rd_en <= 1'b0;
    #1 `CHK(rd_data, e)
    `CHK(rd_refused, r)
  endtask : rd
  task automatic print_verdict();
    $display("Mismatches %0d, comparisons %0d", fails, checked);
    if (fails == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    #1 `CHK(protection_byte, 8'hFF)
    `CHK(fuses, 3'b111)
    `CHK(lock_level, NVMLK_LEVEL_1)
    rd(NVMLK_SEC_SIG, 10'h000, `NVMLK_MAKER_ID, 1'b0);
    rd(NVMLK_SEC_SIG, 10'h001, `NVMLK_PART_ID1, 1'b0);
    rd(NVMLK_SEC_SIG, 10'h002, `NVMLK_PART_ID2, 1'b0);
    rd(NVMLK_SEC_CFG, 10'h000, 8'hFF, 1'b0);
    rd(NVMLK_SEC_CAL, 10'h000, `NVMLK_TRIM_DEFAULT, 1'b0);
    `CHK(osc_trim_register, `NVMLK_TRIM_DEFAULT)
    @(posedge clk) prog_mode <= 1'b1;
    op(1'b1, NVMLK_OP_WRITE, NVMLK_SEC_CODE, 10'h010, 16'h1234, 1'b1);
    op(1'b0, NVMLK_OP_WRITE, NVMLK_SEC_SIG, 10'h000, 16'h0000, 1'b1);
    op(1'b0, NVMLK_OP_SECTION_ERASE, NVMLK_SEC_CAL, 10'h000, 16'h0000, 1'b1);
    op(1'b0, NVMLK_OP_CHIP_ERASE, NVMLK_SEC_CODE, 10'h000, 16'h0000, 1'b0);
    op(1'b0, NVMLK_OP_WRITE, NVMLK_SEC_CODE, 10'h010, 16'h1234, 1'b0);
    rd(NVMLK_SEC_CODE, 10'h010, 8'h34, 1'b0);
    rd(NVMLK_SEC_CODE, 10'h011, 8'h12, 1'b0);
    op(1'b0, NVMLK_OP_WRITE, NVMLK_SEC_CODE, 10'h3FE, 16'hABCD, 1'b0);
    rd(NVMLK_SEC_CODE, 10'h3FF, 8'hAB, 1'b0);
    op(1'b0, NVMLK_OP_WRITE, NVMLK_SEC_CFG, 10'h000, 16'hFFFA, 1'b0);
    `CHK(fuses, 3'b111)
    @(posedge clk) prog_mode <= 1'b0;
    repeat (2) @(posedge clk);
    #1 `CHK(fuses, 3'b010)
    @(posedge clk) prog_mode <= 1'b1;
    op(1'b0, NVMLK_OP_CHIP_ERASE, NVMLK_SEC_CODE, 10'h000, 16'h0000, 1'b0);
    rd(NVMLK_SEC_CFG, 10'h000, 8'hFA, 1'b0);
    op(1'b0, NVMLK_OP_LOCK_WRITE, NVMLK_SEC_CODE, 10'h000, 16'h00FE, 1'b0);
    `CHK(lock_level, NVMLK_LEVEL_2)
    op(1'b0, NVMLK_OP_WRITE, NVMLK_SEC_CODE, 10'h020, 16'h0000, 1'b1);
    op(1'b0, NVMLK_OP_SECTION_ERASE, NVMLK_SEC_CFG, 10'h000, 16'h0000, 1'b1);
    rd(NVMLK_SEC_CODE, 10'h3FF, 8'hFF, 1'b0);
    op(1'b0, NVMLK_OP_LOCK_WRITE, NVMLK_SEC_CODE, 10'h000, 16'h00FC, 1'b0);
    rd(NVMLK_SEC_CODE, 10'h010, 8'hFF, 1'b1);
    op(1'b0, NVMLK_OP_CHIP_ERASE, NVMLK_SEC_CODE, 10'h000, 16'h0000, 1'b0);
    `CHK(protection_byte, 8'hFF)
    op(1'b0, NVMLK_OP_LOCK_WRITE, NVMLK_SEC_CODE, 10'h000, 16'h00FD, 1'b0);
    `CHK(lock_level, NVMLK_LEVEL_3)
    op(1'b0, NVMLK_OP_CHIP_ERASE, NVMLK_SEC_CODE, 10'h000, 16'h0000, 1'b0);
    op(1'b0, NVMLK_OP_SECTION_ERASE, NVMLK_SEC_CFG, 10'h000, 16'h0000, 1'b0);
    rd(NVMLK_SEC_CFG, 10'h000, 8'hFF, 1'b0);
    @(posedge clk) reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1 `CHK(fuses, 3'b111)
    print_verdict();
  end
endmodule : test_nvmlk_core
